// file: logic/read_stream_command.v
// streaming dma read command interpreter
// Functional notes
// R1: opcode 2Ah starts streaming dma read
// R2: count zero means 65536 sectors
// R3: host splits count low current, high previous
// R4: priority bit, finish fast, within limit
// R5: continuous bit disables abort on errors
// R6: continuous: full length, stream error, no failure
// R7: continuous errors: finish, flags, log type
// R8: continuous timeout: stop, set timeout log
// R9: always try full length within limit
// R10: host may hint next read is random
// R11: resume bit continues earlier error recovery
// R12: low three bits select stream settings
// R13: limit equals multiplier times unit microseconds
// R14: zero multiplier uses stream default limit
// R15: no default means no time limit
// R16: time measured from command to completion
// R17: short limits raised to device minimum
// R18: normal mode stops at first failing sector
`timescale 1ns/1ps
`default_nettype none
`include "read_stream_map.vh"
module read_stream_command (
    input wire core_clk,
    input wire rstn,
    input wire clkEn,
    input wire cmdWrite,
    input wire [7:0] cmdCode,
    input wire [7:0] streamOptionFlags,
    input wire [7:0] timeLimitMultiplier,
    input wire [7:0] countLow,
    input wire [7:0] countHigh,
    input wire [47:0] startAddress,
    input wire cfgWrite,
    input wire [2:0] cfgStream,
    input wire [15:0] cfgLimitUs,
    output reg mediaReq,
    output reg [47:0] mediaAddress,
    output reg mediaPriority,
    output reg mediaResume,
    output reg mediaRandomNext,
    output reg [2:0] mediaStream,
    input wire mediaValid,
    output wire mediaReady,
    input wire [15:0] mediaData,
    input wire mediaLast,
    input wire faultChecksum,
    input wire faultMedia,
    input wire faultAddress,
    input wire faultRejected,
    output wire dmaValid,
    input wire dmaReady,
    output wire [15:0] dmaData,
    output reg [7:0] statusReg,
    output reg [7:0] errorReg,
    output reg [47:0] errorAddress,
    output reg completionIrq
);
    // one command at a time: idle takes the command byte, run accepts
    // sector beats from the media side, drain waits for the host to empty
    // the fifo, done is the single cycle in which the completion pulse is high
    localparam ST_IDLE = 4'h1;
    localparam ST_RUN = 4'h2;
    localparam ST_DRAIN = 4'h4;
    localparam ST_DONE = 4'h8;

    reg rstSync1_q;
    reg rstSync2_q;
    wire rstnInt;
    reg [3:0] state_q;
    reg [16:0] remaining_q;
    reg continuous_q;
    reg sawError_q;
    reg timedOut_q;
    reg limitOn_q;
    reg [31:0] timer_q;
    reg [15:0] defLimit_q [0:7];
    reg [7:0] defValid_q;
    wire limitEn;
    wire [31:0] limitCyc;
    wire [2:0] selStream;
    wire anyFault;
    wire [7:0] faultBits;
    wire accept;
    wire fifoEmpty;
    integer i;
    reg [31:0] limitCyc_q;
    wire startCmd;
    wire limitHit;
    wire firstFault;

    // reset released through two flops
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rstnInt = rstSync2_q;

    // stream selector drives default limit lookup [R12]
    assign selStream = streamOptionFlags[`OPT_STREAM_HI:`OPT_STREAM_LO];

    time_limit_calc limitCalc (
        .multiplier(timeLimitMultiplier),
        .defaultLimitUs(defLimit_q[selStream]),
        .defaultValid(defValid_q[selStream]),
        .limitEnable(limitEn),
        .limitCycles(limitCyc)
    );

    // media data goes through the fifo; back-pressure stalls the reader
    stream_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(3)
    ) dataFifo (
        .clk(core_clk),
        .rstn(rstnInt),
        .ce(clkEn),
        .flush(timedOut_q),
        .inValid(mediaValid && state_q == ST_RUN),
        .inReady(mediaReady),
        .inData(mediaData),
        .outValid(dmaValid),
        .outReady(dmaReady),
        .outData(dmaData)
    );
    assign fifoEmpty = !dmaValid;

    // fault flags placed on their error log bit positions [R7]
    assign faultBits = {faultChecksum, faultMedia, 1'b0, faultAddress,
                        1'b0, faultRejected, 2'b00};
    assign anyFault = |faultBits;
    assign accept = mediaValid && mediaReady && state_q == ST_RUN;
    // a command is taken only while idle; writes while busy are dropped
    assign startCmd = cmdWrite && cmdCode == `CMD_READ_STREAM &&
                      state_q == ST_IDLE;
    // compared with the copy taken at the command, so a host rewriting
    // the option registers mid-command cannot move the deadline
    assign limitHit = limitOn_q && timer_q >= limitCyc_q; // [R8] [R16]
    // only the first bad sector of a command is kept as error address
    assign firstFault = accept && anyFault && !sawError_q && !limitHit;

    // sector total from the two count halves; zero asks for 65536 [R2]
    function [16:0] sectorTotal;
        input [7:0] high;
        input [7:0] low;
        begin
            if ({high, low} == 16'h0000)
                sectorTotal = 17'h10000;
            else
                sectorTotal = {1'b0, high, low};
        end
    endfunction

    // ending status: busy clear, ready set, plus the two error summaries
    function [7:0] endStatus;
        input streamErr;
        input failure;
        begin
            endStatus = `STATUS_RESET;
            endStatus[`STS_STREAM_ERR] = streamErr;
            endStatus[`STS_FAILURE] = failure;
        end
    endfunction

    // per-stream default limits from the stream configuration path
    always @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            for (i = 0; i < 8; i = i + 1) defLimit_q[i] <= 16'h0000;
            defValid_q <= 8'h00;
        end else if (clkEn && cfgWrite) begin
            defLimit_q[cfgStream] <= cfgLimitUs;
            defValid_q[cfgStream] <= 1'b1;
        end
    end

    // elapsed time since the command byte; frozen while idle or done [R16]
    always @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            timer_q <= 32'h0;
        end else if (clkEn) begin
            if (startCmd) begin
                timer_q <= 32'h0;
            end else if (state_q == ST_RUN || state_q == ST_DRAIN) begin
                timer_q <= timer_q + 32'h1;
            end
        end
    end

    // first bad sector's address, where a resumed read starts [R11]
    always @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            errorAddress <= 48'h0;
        end else if (clkEn && firstFault) begin
            errorAddress <= mediaAddress;
        end
    end

    // options latched with the command and held until the next one
    always @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            continuous_q <= 1'b0;
            mediaPriority <= 1'b0;
            mediaResume <= 1'b0;
            mediaRandomNext <= 1'b0;
            mediaStream <= 3'h0;
        end else if (clkEn && startCmd) begin
            continuous_q <= streamOptionFlags[`OPT_CONTINUOUS]; // [R5]
            mediaPriority <= streamOptionFlags[`OPT_PRIORITY]; // [R4]
            mediaResume <= streamOptionFlags[`OPT_RESUME]; // [R11]
            mediaRandomNext <= streamOptionFlags[`OPT_RANDOM_NEXT];
            mediaStream <= selStream; // [R12]
        end
    end

    // command sequencer
    always @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            state_q <= ST_IDLE;
            remaining_q <= 17'h00000;
            sawError_q <= 1'b0;
            timedOut_q <= 1'b0;
            limitOn_q <= 1'b0;
            limitCyc_q <= 32'h0;
            mediaReq <= 1'b0;
            mediaAddress <= 48'h0;
            statusReg <= `STATUS_RESET;
            errorReg <= `ERROR_RESET;
            completionIrq <= 1'b0;
        end else if (clkEn) begin
            completionIrq <= 1'b0;
            timedOut_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (startCmd) begin // [R1]
                        // count halves joined, zero means 65536 [R2] [R3]
                        remaining_q <= sectorTotal(countHigh, countLow);
                        mediaAddress <= startAddress;
                        limitOn_q <= limitEn; // [R15]
                        limitCyc_q <= limitCyc; // [R13] [R17]
                        sawError_q <= 1'b0;
                        mediaReq <= 1'b1;
                        statusReg <= 8'h80;
                        errorReg <= `ERROR_RESET;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (limitHit) begin
                        // limit hit: stop, failure clear, log timeout [R8] [R4]
                        mediaReq <= 1'b0;
                        timedOut_q <= 1'b1;
                        errorReg[`ERR_TIMEOUT] <= 1'b1;
                        state_q <= ST_DONE;
                        statusReg <= endStatus(sawError_q, 1'b0);
                        completionIrq <= 1'b1;
                    end else if (accept) begin
                        remaining_q <= remaining_q - 17'h1;
                        mediaAddress <= mediaAddress + 48'h1;
                        if (anyFault) begin
                            errorReg <= errorReg | faultBits; // [R7]
                            sawError_q <= 1'b1;
                        end
                        if (anyFault && !continuous_q) begin
                            // normal mode aborts at failing sector [R18]
                            mediaReq <= 1'b0;
                            state_q <= ST_DRAIN;
                        end else if (remaining_q == 17'h1 || mediaLast) begin
                            // full length even when data bad [R9] [R6]
                            mediaReq <= 1'b0;
                            state_q <= ST_DRAIN;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (limitHit) begin
                        timedOut_q <= 1'b1;
                        errorReg[`ERR_TIMEOUT] <= 1'b1; // [R8]
                        statusReg <= endStatus(sawError_q, 1'b0);
                        completionIrq <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (fifoEmpty) begin
                        // continuous mode reports stream error only [R6] [R7]
                        statusReg <= endStatus(sawError_q && continuous_q,
                                               sawError_q && !continuous_q);
                        completionIrq <= 1'b1;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: logic/read_stream_map.vh
// constants for the streaming read command interpreter
`ifndef READ_STREAM_MAP_VH
`define READ_STREAM_MAP_VH
`define CMD_READ_STREAM 8'h2A
`define OPT_PRIORITY 7
`define OPT_CONTINUOUS 6
`define OPT_RANDOM_NEXT 5
`define OPT_RESUME 4
`define OPT_STREAM_HI 2
`define OPT_STREAM_LO 0
`define ERR_CHECKSUM 7
`define ERR_MEDIA 6
`define ERR_ADDRESS 4
`define ERR_REJECTED 2
`define ERR_TIMEOUT 0
`define STS_BUSY 7
`define STS_READY 6
`define STS_STREAM_ERR 5
`define STS_FAILURE 0
`define STATUS_RESET 8'h40
`define ERROR_RESET 8'h00
`define LIMIT_UNIT_US 32'd10
`define LIMIT_MIN_US 32'd50
`define CLK_MHZ 32'd10
`define FIFO_DEPTH 8
`define FIFO_WIDTH 16
`endif

// file: logic/stream_fifo.v
// small synchronous fifo between media reader and host transfer
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire flush,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    // handshakes, full and empty from the occupancy count
    assign inReady = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // storage has no reset, only the pointers and the count need one
    always @(posedge clk) begin
        if (ce && push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= 3'h0;
            rdPtr_q <= 3'h0;
            count_q <= 4'h0;
        end else if (ce) begin
            if (flush) begin
                wrPtr_q <= 3'h0;
                rdPtr_q <= 3'h0;
                count_q <= 4'h0;
            end else begin
                if (push) wrPtr_q <= wrPtr_q + 3'h1;
                if (pop) rdPtr_q <= rdPtr_q + 3'h1;
                if (push && !pop) count_q <= count_q + 4'h1;
                else if (pop && !push) count_q <= count_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/time_limit_calc.v
// completion time limit selection and conversion to clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "read_stream_map.vh"
module time_limit_calc (
    input wire [7:0] multiplier,
    input wire [15:0] defaultLimitUs,
    input wire defaultValid,
    output reg limitEnable,
    output reg [31:0] limitCycles
);
    reg [31:0] us;

    // explicit multiplier wins, else stream default, else no limit
    always @* begin
        us = 32'h0;
        limitEnable = 1'b0;
        if (multiplier != 8'h00) begin
            us = {24'h0, multiplier} * `LIMIT_UNIT_US; // [R13]
            limitEnable = 1'b1;
        end else if (defaultValid && defaultLimitUs != 16'h0000) begin
            us = {16'h0, defaultLimitUs}; // [R14]
            limitEnable = 1'b1;
        end // otherwise unlimited [R15]
        if (limitEnable && us < `LIMIT_MIN_US) begin
            us = `LIMIT_MIN_US; // [R17]
        end
        limitCycles = us * `CLK_MHZ;
    end
endmodule
`default_nettype wire

// file: dv/read_stream_checker.sv
// port-level timing relations of the streaming read command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "read_stream_map.vh"
module read_stream_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] streamOptionFlags,
    input wire logic [47:0] startAddress,
    input wire logic mediaReq,
    input wire logic [47:0] mediaAddress,
    input wire logic mediaPriority,
    input wire logic [2:0] mediaStream,
    input wire logic dmaValid,
    input wire logic dmaReady,
    input wire logic [15:0] dmaData,
    input wire logic [7:0] statusReg,
    input wire logic [7:0] errorReg,
    input wire logic completionIrq
);
    logic [2:0] optStream;
    logic optPriority;
    logic newCmd;
    // option fields split out so that $past sees plain signals
    assign optStream = streamOptionFlags[2:0];
    assign optPriority = streamOptionFlags[7];
    assign newCmd = cmdWrite && !statusReg[7] && !completionIrq;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_start;
        newCmd && cmdCode == `CMD_READ_STREAM |=> statusReg == 8'h80;
    endproperty
    a_start: assert property (p_start) else $error("read not started");
    property p_ignore;
        newCmd && cmdCode != `CMD_READ_STREAM |=> $stable(statusReg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("bad code taken");
    property p_irq;
        completionIrq |=> !completionIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq too long");
    property p_done;
        completionIrq |-> ##[0:1] !statusReg[`STS_BUSY];
    endproperty
    a_done: assert property (p_done) else $error("busy at end");
    property p_media;
        mediaReq |-> statusReg[`STS_BUSY] || $past(statusReg[`STS_BUSY]);
    endproperty
    a_media: assert property (p_media) else $error("read while idle");
    property p_hold;
        dmaValid && !dmaReady && !completionIrq
            |=> dmaValid && $stable(dmaData);
    endproperty
    a_hold: assert property (p_hold) else $error("word lost");
    property p_nofail;
        completionIrq |-> ##[0:1] !(statusReg[5] && statusReg[0]);
    endproperty
    a_nofail: assert property (p_nofail) else $error("both flags");
    property p_cto;
        $rose(errorReg[`ERR_TIMEOUT])
            |-> ($past(completionIrq) or ##[0:1] completionIrq);
    endproperty
    a_cto: assert property (p_cto) else $error("timeout no end");
    property p_opts;
        $rose(mediaReq) |-> mediaStream == $past(optStream)
            && mediaPriority == $past(optPriority);
    endproperty
    a_opts: assert property (p_opts) else $error("options");
    property p_addr;
        $rose(mediaReq) |-> mediaAddress == $past(startAddress);
    endproperty
    a_addr: assert property (p_addr) else $error("start address");
endmodule
bind read_stream_command read_stream_checker chk_u (
    .core_clk, .rstn, .cmdWrite, .cmdCode, .streamOptionFlags,
    .startAddress, .mediaReq, .mediaAddress, .mediaPriority, .mediaStream,
    .dmaValid, .dmaReady, .dmaData, .statusReg, .errorReg, .completionIrq
);
`default_nettype wire

// file: dv/media_model.sv
// media side stand-in that feeds numbered sector beats
`timescale 1ns/1ps
`default_nettype none
module media_model (
    input wire logic core_clk,
    input wire logic mediaReq,
    input wire logic mediaReady,
    input wire logic stall,
    input wire logic [16:0] beats,
    input wire logic [16:0] faultAt,
    input wire logic [1:0] faultKind,
    output logic mediaValid,
    output logic [15:0] mediaData,
    output logic mediaLast,
    output logic [3:0] faults
);
    logic [16:0] idx;
    // index restarts whenever no read runs, so no reset is needed
    always @(posedge core_clk) begin
        if (!mediaReq)
            idx <= 17'h00000;
        else if (mediaValid && mediaReady)
            idx <= idx + 17'h00001;
    end
    // idle data toggles each cycle so stale words cannot pass
    assign mediaValid = mediaReq && !stall && idx < beats;
    assign mediaData = mediaValid ? 16'hA000 + idx[15:0] : {16{core_clk}};
    assign mediaLast = mediaValid && idx == beats - 17'h00001;
    assign faults = (mediaValid && idx == faultAt) ? 4'h1 << faultKind : 4'h0;
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the streaming read command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "read_stream_map.vh"
module tb;
    logic core_clk = 0, rstn = 0, cmdWrite = 0, cfgWrite = 0, dmaReady = 1;
    logic stall = 0, sawFull = 0;
    logic [7:0] cmdCode = 8'h00, streamOptionFlags = 8'h00;
    logic [7:0] timeLimitMultiplier = 8'h00, countLow = 8'h00;
    logic [7:0] countHigh = 8'h00, statusReg, errorReg;
    logic [2:0] cfgStream = 3'h0, mediaStream;
    logic [15:0] cfgLimitUs = 16'h0000, dmaData, mediaData;
    logic [16:0] beats = 17'h00000, faultAt = 17'h1FFFF;
    logic [1:0] faultKind = 2'h0;
    logic [47:0] startAddress = 48'h000012345678, mediaAddress, errorAddress;
    logic [3:0] faults;
    logic mediaReq, mediaReady, mediaValid, mediaLast, dmaValid;
    logic completionIrq, mediaPriority, mediaResume, mediaRandomNext;
    logic [7:0] errExp [4] = '{8'h80, 8'h40, 8'h10, 8'h04};
    int error_cnt = 0, comparisons = 0, words = 0, elapsed, lim;
    always #50 core_clk = ~core_clk;
    read_stream_command dut_u (
        .core_clk, .rstn, .clkEn(1'b1), .cmdWrite, .cmdCode,
        .streamOptionFlags, .timeLimitMultiplier, .countLow, .countHigh,
        .startAddress, .cfgWrite, .cfgStream, .cfgLimitUs, .mediaReq,
        .mediaAddress, .mediaPriority, .mediaResume, .mediaRandomNext,
        .mediaStream, .mediaValid, .mediaReady, .mediaData, .mediaLast,
        .faultChecksum(faults[0]), .faultMedia(faults[1]),
        .faultAddress(faults[2]), .faultRejected(faults[3]), .dmaValid,
        .dmaReady, .dmaData, .statusReg, .errorReg, .errorAddress,
        .completionIrq
    );
    media_model media_u (
        .core_clk, .mediaReq, .mediaReady, .stall, .beats, .faultAt,
        .faultKind, .mediaValid, .mediaData, .mediaLast, .faults
    );
    task automatic check(input string what, input logic [47:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // host side: every taken word must follow the media numbering
    always @(posedge core_clk) begin
        if (dmaValid === 1'b1 && dmaReady === 1'b1) begin
            check("dmaData", dmaData, 16'(16'hA000 + words[15:0]));
            words++;
        end
    end
    task automatic run_cmd(input logic [7:0] fl, ml, input logic [15:0] cnt,
            input logic [16:0] fa, input int stallLen, hostLen);
        words = 0;
        sawFull = 0;
        @(posedge core_clk);
        streamOptionFlags <= fl;
        timeLimitMultiplier <= ml;
        {countHigh, countLow} <= cnt;
        beats <= (cnt == 16'h0000) ? 17'h10000 : {1'b0, cnt};
        faultAt <= fa;
        stall <= stallLen != 0;
        dmaReady <= hostLen == 0;
        cmdCode <= `CMD_READ_STREAM;
        cmdWrite <= 1'b1;
        // elapsed counts edges from the one that takes the command
        for (elapsed = 0; elapsed < 80000; elapsed++) begin
            @(posedge core_clk);
            cmdWrite <= 1'b0;
            if (elapsed == stallLen)
                stall <= 1'b0;
            if (elapsed == hostLen)
                dmaReady <= 1'b1;
            if (mediaReq === 1'b1 && mediaReady === 1'b0)
                sawFull = 1;
            if (completionIrq === 1'b1)
                break;
        end
        check("irqSeen", elapsed < 80000, 1'b1);
        repeat (2) @(posedge core_clk);
    endtask
    task automatic s_clean;
        run_cmd(8'h83, 8'h00, 16'h0103, 17'h1FFFF, 0, 40);
        check("words", words, 16'h0103);
        check("status", statusReg, 8'h40);
        check("error", errorReg, 8'h00);
        check("fifoFull", sawFull, 1'b1);
        check("priority", mediaPriority, 1'b1);
        check("stream", mediaStream, 3'h3);
    endtask
    task automatic s_cont_err;
        for (int k = 0; k < 4; k++) begin
            faultKind <= k[1:0];
            run_cmd(8'h40, 8'h00, 16'h0006, 17'h00002, 0, 0);
            check("words", words, 16'h0006);
            check("status", statusReg, 8'h60);
            check("error", errorReg, errExp[k]);
        end
    endtask
    task automatic s_norm_err;
        faultKind <= 2'h1;
        run_cmd(8'h35, 8'h00, 16'h0006, 17'h00002, 0, 0);
        check("words", words, 16'h0003);
        check("status", statusReg, 8'h41);
        check("error", errorReg, 8'h40);
        check("errAddr", errorAddress, startAddress + 48'h2);
        check("resume", mediaResume, 1'b1);
        check("randomNext", mediaRandomNext, 1'b1);
        check("stream", mediaStream, 3'h5);
    endtask
    task automatic s_timeout(input logic [7:0] fl, ml, input int us);
        lim = (us < `LIMIT_MIN_US ? `LIMIT_MIN_US : us) * `CLK_MHZ;
        run_cmd(fl, ml, 16'h0004, 17'h1FFFF, 100000, 0);
        check("late", elapsed >= lim - 2 && elapsed <= lim + 3, 1'b1);
        check("cto", errorReg[`ERR_TIMEOUT], 1'b1);
        check("busyFail", {statusReg[7], statusReg[0]}, 2'h0);
    endtask
    task automatic s_default;
        @(posedge core_clk);
        cfgStream <= 3'h2;
        cfgLimitUs <= 16'h003C;
        cfgWrite <= 1'b1;
        @(posedge core_clk);
        cfgWrite <= 1'b0;
        s_timeout(8'h42, 8'h00, 16'h003C);
        run_cmd(8'h45, 8'h00, 16'h0004, 17'h1FFFF, 1200, 0);
        check("words", words, 16'h0004);
        check("error", errorReg, 8'h00);
        @(posedge core_clk);
        cmdCode <= 8'h24;
        cmdWrite <= 1'b1;
        @(posedge core_clk);
        cmdWrite <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("status", statusReg, 8'h40);
    endtask
    task automatic s_max;
        run_cmd(8'h00, 8'h00, 16'h0000, 17'h1FFFF, 0, 0);
        check("words", words, 48'h10000);
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence after the 20-cycle reset
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge core_clk);
        check("status", statusReg, `STATUS_RESET);
        check("error", errorReg, `ERROR_RESET);
        s_clean;
        s_cont_err;
        s_norm_err;
        s_timeout(8'h40, 8'h01, 1 * `LIMIT_UNIT_US);
        s_timeout(8'h40, 8'h07, 7 * `LIMIT_UNIT_US);
        s_default;
        s_max;
        finish_test;
    end
    // watchdog sized above the 65536-sector run plus the rest
    initial begin
        repeat (95000) @(posedge core_clk);
        error_cnt++;
        finish_test;
    end
endmodule
`default_nettype wire
